// ===== src/io_consts.svh
`ifndef IO_CONSTS_SVH
`define IO_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define IO_NUM_PORTS   4
`define IO_PORT_W      8
`define IO_NUM_CELLS   16
`define IO_ADDR_W      6
`define IO_PORT_A      2'h0
`define IO_PORT_B      2'h1
`define IO_PORT_C      2'h2
`define IO_PORT_D      2'h3

// ----------------------------------------------------------------
// Register kinds: byte offset = kind * 4 + port
// ----------------------------------------------------------------
`define KIND_PIN_INPUT   4'h0
`define KIND_OUTPUT_DATA 4'h1
`define KIND_OUT_CELLS   4'h2
`define KIND_CELL_MASK   4'h3
`define KIND_IN_CELLS    4'h4
`define KIND_DRV_STATUS  4'h5
`define KIND_DIRECTION   4'h6
`define KIND_DRIVE_SEL   4'h7
`define KIND_CONTROL     4'h8

// ----------------------------------------------------------------
// Reset values and per-port bit masks
// ----------------------------------------------------------------
`define IO_REG_RESET   8'h00
`define IO_CELL_RESET  16'h0000
`define MASK_FULL      8'hff
`define MASK_PORT_D    8'h07
`define OD_MASK_AB     8'hf0
`define SLEW_MASK_AB   8'h0f
`define OD_MASK_C      8'hff
`define SLEW_MASK_D    8'h07

// ----------------------------------------------------------------
// Dedicated pin positions
// ----------------------------------------------------------------
`define PD_STROBE_BIT  0
`define PD_CLOCK_BIT   1
`define PD_SELECT_BIT  2
`define PC_BYTE_EN_BIT 7

`endif

// ===== src/io_ports_pkg.sv
`include "io_consts.svh"

package io_ports_pkg;
  typedef logic [`IO_PORT_W-1:0] byte_type;
  typedef logic [`IO_NUM_PORTS-1:0][`IO_PORT_W-1:0] port_array_type;
  typedef logic [3:0] reg_kind_type;
  typedef logic [1:0] port_sel_type;
endpackage

// ===== src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,    // System clock
  input  wire logic             sys_rst, // Async reset, high
  input  wire logic [WIDTH-1:0] rawIn,   // Asynchronous pin levels
  output logic      [WIDTH-1:0] stable   // Filtered level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  // Accept a change only when the last two stages agree
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_stable[i] = stage3[i];
      end
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      stable <= '0;
    end else begin
      stage1 <= rawIn;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
    end
  end
endmodule

`default_nettype wire

// ===== src/configurable_io_ports.sv
// Functional notes
// (RQ1) Pin drives when direction or enable term
// (RQ2) Input read returns live synchronised pin
// (RQ3) Output data stored, driven, read back
// (RQ4) Cell location reads outputs, writes load
// (RQ5) Mask bit one blocks cell load
// (RQ6) Input cells latch pins, readable, exported
// (RQ7) Status register reports each driver state
// (RQ8) Cell groups route to neighbouring ports
// (RQ9) First ports: low slew, high open drain
// (RQ10) Only first port serves as data bus
// (RQ11) Peripheral buffer mode on first port only
// (RQ12) Third/fourth ports: no address out; C open-drain
// (RQ13) Third port top pin as byte enable
// (RQ14) Three selects, polarity configurable
// (RQ15) Select pins enabled by term or direction
// (RQ16) Fourth port dedicated inputs; select blocks registers
// (RQ17) Fourth port drive uses three bits only
// (RQ18) Power-down holds I/O, tri-states bus pins
// (RQ19) Direction one output, reset to input
// (RQ20) Control bit selects address out, default off
// (RQ21) Drive bit one gives open drain
// (RQ22) Drive bit one gives fast slew
// (RQ23) One write loads all unmasked cells; code loads only the addressed 8-cell group
`timescale 1ns/1ps
`default_nettype none
`include "io_consts.svh"

module configurable_io_ports (
  input  wire logic                        mclk,          // 10 MHz clock
  input  wire logic                        sys_rst,       // Async reset, high
  input  wire logic [`IO_ADDR_W-1:0]       mcuAddr,       // Register offset
  input  wire io_ports_pkg::byte_type      mcuWrData,     // Write data
  input  wire logic                        mcuWr,         // Write strobe
  input  wire logic                        mcuRd,         // Read strobe
  input  wire logic                        ioSelect,      // Register block select
  output io_ports_pkg::byte_type           mcuRdData,     // Read data
  output logic                             mcuRdValid,    // Read data valid
  input  wire io_ports_pkg::port_array_type padIn,        // Pin levels
  output io_ports_pkg::port_array_type     padOut,        // Pin output value
  output io_ports_pkg::port_array_type     padOe,         // Pin output enable
  output io_ports_pkg::port_array_type     slewFast,      // Fast slew select
  input  wire io_ports_pkg::port_array_type oeTerm,       // Array enable terms
  input  wire io_ports_pkg::port_array_type cellPinSel,   // Pin fed by logic
  input  wire logic [`IO_NUM_CELLS-1:0]    cellLogic,     // Cell next values
  input  wire logic                        logicClkEn,    // Internal cell clock
  input  wire logic                        imcLatchEn,    // Internal latch strobe
  input  wire logic                        routeFirstToB, // First group to B
  input  wire logic                        routeSecondToC,// Second group to C
  input  wire logic [2:0]                  ecsTerm,       // Select product terms
  input  wire logic [2:0]                  ecsActiveHigh, // Select polarity
  input  wire io_ports_pkg::byte_type      addrOutA,      // Latched address A
  input  wire io_ports_pkg::byte_type      addrOutB,      // Latched address B
  input  wire logic                        dataPortMode,  // Port A data bus
  input  wire logic                        periphMode,    // Port A buffer
  input  wire io_ports_pkg::byte_type      busDriveData,  // Bus data to pins
  input  wire logic                        busDriveEn,    // Bus drive enable
  input  wire logic                        dbeEnable,     // PC7 byte enable use
  input  wire logic                        aleOnPin,      // PD0 strobe use
  input  wire logic                        clkinOnPin,    // PD1 clock use
  input  wire logic                        csiOnPin,      // PD2 select use
  input  wire logic                        powerDown,     // Power-down active
  output io_ports_pkg::port_array_type     inputCellBus,  // Input cells out
  output logic [`IO_NUM_CELLS-1:0]         cellOutputs,   // Output cells
  output io_ports_pkg::byte_type           busPinData,    // Port A pin data
  output logic                             dataByteEnable,// Byte enable in
  output logic                             addrStrobe,    // Strobe in
  output logic                             memDisable     // Memories deselected
);
  import io_ports_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  port_array_type pinSync, dirReg, dataOutReg, drvReg, imcReg, pinDrive;
  port_array_type next_dir, next_dataOut, next_drv, next_imc, next_pinDrive;
  port_array_type next_padOut, next_padOe, next_slew;
  logic [1:0][`IO_PORT_W-1:0] ctlReg, next_ctl;
  logic [`IO_NUM_CELLS-1:0]   maskReg, next_mask, next_cells;
  byte_type     next_rdData;
  logic         next_rdValid, alePrev, clkPrev;
  reg_kind_type kind;
  port_sel_type psel;
  logic         access, csiBlock, cellTick, imcTick;

  function automatic byte_type portMask(input port_sel_type p);
    portMask = (p == `IO_PORT_D) ? `MASK_PORT_D : `MASK_FULL;
  endfunction

  function automatic logic wrHit(input logic acc, input logic wr,
                                 input reg_kind_type k, input reg_kind_type want);
    wrHit = acc & wr & (k == want);
  endfunction

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  pin_sync #(.WIDTH(`IO_NUM_PORTS * `IO_PORT_W)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .rawIn   (padIn),
    .stable  (pinSync)
  );

  // ----------------------------------------------------------------
  // Register access and cell updates
  // ----------------------------------------------------------------
  always_comb begin
    kind = mcuAddr[5:2];
    psel = mcuAddr[1:0];
    // (RQ16) select blocks registers
    csiBlock = csiOnPin & pinSync[3][`PD_SELECT_BIT];
    // Bus is blocked in power-down, so MCU I/O levels simply hold
    access = ioSelect & ~csiBlock & ~powerDown;
    // (RQ16) dedicated clock input
    cellTick = clkinOnPin ? (pinSync[3][`PD_CLOCK_BIT] & ~clkPrev) : logicClkEn;
    imcTick = aleOnPin ? (pinSync[3][`PD_STROBE_BIT] & ~alePrev) : imcLatchEn;
    next_dir = dirReg;
    next_dataOut = dataOutReg;
    next_drv = drvReg;
    next_ctl = ctlReg;
    next_mask = maskReg;
    next_imc = imcReg;
    next_cells = cellOutputs;
    next_rdData = mcuRdData;
    next_rdValid = access & mcuRd;
    if (cellTick) begin
      next_cells = cellLogic;
    end
    // (RQ6) input cells latch
    if (imcTick) begin
      for (int p = 0; p < 3; p++) begin
        next_imc[p] = pinSync[p];
      end
    end
    // (RQ19) direction register write
    if (wrHit(access, mcuWr, kind, `KIND_DIRECTION)) begin
      next_dir[psel] = mcuWrData & portMask(psel);
    end
    // (RQ3) output data store
    if (wrHit(access, mcuWr, kind, `KIND_OUTPUT_DATA)) begin
      next_dataOut[psel] = mcuWrData & portMask(psel);
    end
    // (RQ17) three drive bits on D
    if (wrHit(access, mcuWr, kind, `KIND_DRIVE_SEL)) begin
      next_drv[psel] = mcuWrData & portMask(psel);
    end
    // (RQ12) control only on A and B
    if (wrHit(access, mcuWr, kind, `KIND_CONTROL) && !psel[1]) begin
      next_ctl[psel[0]] = mcuWrData;
    end
    // (RQ5) mask register write
    if (wrHit(access, mcuWr, kind, `KIND_CELL_MASK) && !psel[1]) begin
      next_mask[psel[0]*8 +: 8] = mcuWrData;
    end
    // (RQ23) unmasked cells load together; MCU write wins over the tick
    if (wrHit(access, mcuWr, kind, `KIND_OUT_CELLS) && !psel[1]) begin
      next_cells[psel[0]*8 +: 8] = (mcuWrData & ~maskReg[psel[0]*8 +: 8])
                                 | (next_cells[psel[0]*8 +: 8] & maskReg[psel[0]*8 +: 8]);
    end
    if (access && mcuRd) begin
      case (kind)
        // (RQ2) live pin read
        `KIND_PIN_INPUT:   next_rdData = pinSync[psel] & portMask(psel);
        `KIND_OUTPUT_DATA: next_rdData = dataOutReg[psel];
        // (RQ4) cell outputs read
        `KIND_OUT_CELLS:   next_rdData = psel[1] ? `IO_REG_RESET : cellOutputs[psel[0]*8 +: 8];
        `KIND_CELL_MASK:   next_rdData = psel[1] ? `IO_REG_RESET : maskReg[psel[0]*8 +: 8];
        `KIND_IN_CELLS:    next_rdData = imcReg[psel];
        // (RQ7) driver state readback
        `KIND_DRV_STATUS:  next_rdData = pinDrive[psel];
        `KIND_DIRECTION:   next_rdData = dirReg[psel];
        `KIND_DRIVE_SEL:   next_rdData = drvReg[psel];
        `KIND_CONTROL:     next_rdData = psel[1] ? `IO_REG_RESET : ctlReg[psel[0]];
        default:           next_rdData = `IO_REG_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin output path
  // ----------------------------------------------------------------
  always_comb begin
    byte_type odMask, slewMask, val, drv;
    odMask = '0;
    slewMask = '0;
    val = '0;
    drv = '0;
    for (int p = 0; p < `IO_NUM_PORTS; p++) begin
      // (RQ9) (RQ12) (RQ17) per-port drive masks
      case (p)
        0, 1:    begin odMask = `OD_MASK_AB; slewMask = `SLEW_MASK_AB; end
        2:       begin odMask = `OD_MASK_C;  slewMask = '0;            end
        default: begin odMask = '0;          slewMask = `SLEW_MASK_D;  end
      endcase
      // (RQ1) (RQ15) direction or term
      drv = (dirReg[p] | oeTerm[p]) & portMask(p[1:0]);
      val = dataOutReg[p];
      for (int b = 0; b < `IO_PORT_W; b++) begin
        // (RQ8) cell group routing
        if (cellPinSel[p][b]) begin
          case (p)
            0:       val[b] = routeFirstToB ? 1'b0 : cellOutputs[b];
            1:       val[b] = routeFirstToB ? cellOutputs[b]
                            : (routeSecondToC ? 1'b0 : cellOutputs[8+b]);
            2:       val[b] = routeSecondToC ? cellOutputs[8+b] : 1'b0;
            // (RQ14) select polarity
            default: val[b] = (b < 3) ? ~(ecsTerm[b] ^ ecsActiveHigh[b]) : 1'b0;
          endcase
        end
      end
      // (RQ20) address out on A/B
      if (p < 2) begin
        val = (ctlReg[p] & (p == 0 ? addrOutA : addrOutB)) | (~ctlReg[p] & val);
        drv = (ctlReg[p] & ((dirReg[p] & ctlReg[p]) | oeTerm[p])) | (~ctlReg[p] & drv);
      end
      // (RQ10) (RQ11) data and buffer modes exist on port A only
      if (p == 0 && (dataPortMode || periphMode)) begin
        val = busDriveData;
        // (RQ18) bus pins tri-state in power-down
        drv = {`IO_PORT_W{busDriveEn & ~powerDown}};
      end
      next_pinDrive[p] = drv;
      // (RQ21) open drain only pulls low
      next_padOe[p] = drv & ~(drvReg[p] & odMask & val);
      next_padOut[p] = val & ~(drvReg[p] & odMask);
      // (RQ22) fast slew select
      next_slew[p] = drvReg[p] & slewMask;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {dirReg, dataOutReg, drvReg, imcReg, pinDrive} <= '0;
      {padOut, padOe, slewFast, inputCellBus, ctlReg} <= '0;
      {mcuRdValid, alePrev, clkPrev, dataByteEnable, addrStrobe, memDisable} <= '0;
      maskReg <= `IO_CELL_RESET;
      cellOutputs <= `IO_CELL_RESET;
      mcuRdData <= `IO_REG_RESET;
      busPinData <= `IO_REG_RESET;
    end else begin
      dirReg <= next_dir;
      dataOutReg <= next_dataOut;
      drvReg <= next_drv;
      ctlReg <= next_ctl;
      maskReg <= next_mask;
      cellOutputs <= next_cells;
      imcReg <= next_imc;
      pinDrive <= next_pinDrive;
      padOut <= next_padOut;
      padOe <= next_padOe;
      slewFast <= next_slew;
      mcuRdData <= next_rdData;
      mcuRdValid <= next_rdValid;
      alePrev <= pinSync[3][`PD_STROBE_BIT];
      clkPrev <= pinSync[3][`PD_CLOCK_BIT];
      inputCellBus <= next_imc;
      busPinData <= pinSync[0];
      // (RQ13) byte enable input
      dataByteEnable <= dbeEnable & pinSync[2][`PC_BYTE_EN_BIT];
      addrStrobe <= aleOnPin & pinSync[3][`PD_STROBE_BIT];
      memDisable <= csiBlock;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_oe_cause;
    @(posedge mclk) disable iff (sys_rst)
      padOe[1][0] |-> $past(dirReg[1][0] | oeTerm[1][0]);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin driven without cause"); // RQ1
  property p_input_default;
    @(posedge mclk) disable iff (sys_rst)
      (dirReg[2] == 8'h00 && oeTerm[2] == 8'h00) |=> (padOe[2] == 8'h00);
  endproperty
  a_input_default: assert property (p_input_default) else $error("pin not input"); // RQ19
  // Write, one idle cycle, then read back: the pace of a plain bus master
  property p_data_readback;
    @(posedge mclk) disable iff (sys_rst)
      (wrHit(access, mcuWr, kind, `KIND_OUTPUT_DATA) && psel == `IO_PORT_C) ##1 !mcuWr
      ##1 (access && mcuRd && !mcuWr && kind == `KIND_OUTPUT_DATA && psel == `IO_PORT_C)
      |=> (mcuRdData == $past(mcuWrData, 3));
  endproperty
  a_data_readback: assert property (p_data_readback) else $error("data readback wrong"); // RQ3
  property p_mask_blocks;
    @(posedge mclk) disable iff (sys_rst)
      (wrHit(access, mcuWr, kind, `KIND_OUT_CELLS) && psel == `IO_PORT_A
       && maskReg[7] && !cellTick) |=> $stable(cellOutputs[7]);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked cell loaded"); // RQ5
  property p_unmasked_load;
    @(posedge mclk) disable iff (sys_rst)
      (wrHit(access, mcuWr, kind, `KIND_OUT_CELLS) && psel == `IO_PORT_B && !cellTick)
      |=> (cellOutputs[15:8] == (($past(mcuWrData) & ~$past(maskReg[15:8]))
                               | ($past(cellOutputs[15:8]) & $past(maskReg[15:8]))));
  endproperty
  a_unmasked_load: assert property (p_unmasked_load) else $error("cell load wrong"); // RQ23
  property p_status_read;
    @(posedge mclk) disable iff (sys_rst)
      (access && mcuRd && kind == `KIND_DRV_STATUS && psel == `IO_PORT_B)
      |=> (mcuRdData == $past(pinDrive[1]));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // RQ7
  property p_port_d_narrow;
    @(posedge mclk) disable iff (sys_rst)
      (slewFast[3][7:3] == 5'h00) && (padOe[3][7:3] == 5'h00);
  endproperty
  a_port_d_narrow: assert property (p_port_d_narrow) else $error("port D upper bits"); // RQ17
  property p_pdown_tristate;
    @(posedge mclk) disable iff (sys_rst)
      (powerDown && dataPortMode) |=> (padOe[0] == 8'h00);
  endproperty
  a_pdown_tristate: assert property (p_pdown_tristate) else $error("bus pins driven"); // RQ18
  property p_select_blocks;
    @(posedge mclk) disable iff (sys_rst)
      (csiBlock && mcuRd) |=> (!mcuRdValid && memDisable);
  endproperty
  a_select_blocks: assert property (p_select_blocks) else $error("access not blocked"); // RQ16
  property p_open_drain_c;
    @(posedge mclk) disable iff (sys_rst)
      $past(drvReg[2][5]) |-> (padOut[2][5] == 1'b0);
  endproperty
  a_open_drain_c: assert property (p_open_drain_c) else $error("open drain drives high"); // RQ12
  c_write_read: cover property (@(posedge mclk) disable iff (sys_rst)
    wrHit(access, mcuWr, kind, `KIND_OUTPUT_DATA) ##3 mcuRdValid);
  c_cell_load: cover property (@(posedge mclk) disable iff (sys_rst)
    wrHit(access, mcuWr, kind, `KIND_OUT_CELLS) && maskReg != 16'h0000);
  c_power_down: cover property (@(posedge mclk) disable iff (sys_rst)
    powerDown && periphMode && busDriveEn);
endmodule

`default_nettype wire

// ===== tb/mcu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_consts.svh"

module mcu_bus_model (
  input  wire logic                   mclk,       // Bus clock
  output logic [`IO_ADDR_W-1:0]       mcuAddr,    // Register offset
  output io_ports_pkg::byte_type      mcuWrData,  // Write data
  output logic                        mcuWr,      // Write strobe
  output logic                        mcuRd,      // Read strobe
  output logic                        ioSelect,   // Block select
  input  wire io_ports_pkg::byte_type mcuRdData,  // Returned data
  input  wire logic                   mcuRdValid  // Returned data valid
);
  import io_ports_pkg::*;

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Idle bus holds junk, not zeros, so a design reading it out of turn shows up
  initial begin
    {mcuAddr, mcuWrData, mcuWr, mcuRd, ioSelect} = {6'h2a, 8'h5a, 3'h0};
  end

  // One write; lines are flipped afterwards because a released bus keeps no value
  task automatic wr(input logic [7:0] a, input byte_type v);
    @(posedge mclk);
    #1;
    {mcuAddr, mcuWrData, mcuWr, ioSelect} = {a[5:0], v, 2'b11};
    @(posedge mclk);
    #1;
    {mcuAddr, mcuWrData, mcuWr, ioSelect} = {~a[5:0], ~v, 2'b00};
  endtask

  // One read; the answer may trail the taking edge, so allow two more edges
  task automatic rd(input logic [7:0] a, output byte_type v, output logic got);
    int i;
    @(posedge mclk);
    #1;
    {mcuAddr, mcuRd, ioSelect} = {a[5:0], 2'b11};
    @(posedge mclk);
    #1;
    {mcuAddr, mcuRd, ioSelect} = {~a[5:0], 2'b00};
    for (i = 0; i < 2 && mcuRdValid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    got = (mcuRdValid === 1'b1);
    v = mcuRdData;
  endtask
endmodule
`default_nettype wire

// ===== tb/configurable_io_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_consts.svh"

`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end

module configurable_io_ports_tb;
  import io_ports_pkg::*;
  logic                     mclk, sys_rst, mcuWr, mcuRd, ioSelect, mcuRdValid, ok;
  logic [`IO_ADDR_W-1:0]    mcuAddr;
  byte_type                 mcuWrData, mcuRdData, addrOutA, addrOutB, busDriveData, busPinData, d;
  port_array_type           padIn, padOut, padOe, slewFast, oeTerm, cellPinSel, inputCellBus;
  logic [`IO_NUM_CELLS-1:0] cellLogic, cellOutputs;
  logic [2:0]               ecsTerm, ecsActiveHigh;
  logic                     logicClkEn, imcLatchEn, routeFirstToB, routeSecondToC, dataPortMode;
  logic                     periphMode, busDriveEn, dbeEnable, aleOnPin, clkinOnPin, csiOnPin;
  logic                     powerDown, dataByteEnable, addrStrobe, memDisable;
  int                       failures = 0, nChecks = 0, cyc = 0;
  // Rows: offset, written byte, byte read back
  logic [23:0]              rows [9] = '{24'h04a5a5, 24'h07ff07, 24'h1fff07, 24'h1a3c3c,
                                         24'h22ff00, 24'h208181, 24'h0c0f0f, 24'h0eff00, 24'h24ff00};
  logic [7:0]               zeroAddrs [5] = '{8'h04, 8'h1a, 8'h0c, 8'h20, 8'h1f};

  configurable_io_ports DUT (
    .mclk, .sys_rst, .mcuAddr, .mcuWrData, .mcuWr, .mcuRd, .ioSelect, .mcuRdData, .mcuRdValid,
    .padIn, .padOut, .padOe, .slewFast, .oeTerm, .cellPinSel, .cellLogic, .logicClkEn,
    .imcLatchEn, .routeFirstToB, .routeSecondToC, .ecsTerm, .ecsActiveHigh, .addrOutA,
    .addrOutB, .dataPortMode, .periphMode, .busDriveData, .busDriveEn, .dbeEnable, .aleOnPin,
    .clkinOnPin, .csiOnPin, .powerDown, .inputCellBus, .cellOutputs, .busPinData,
    .dataByteEnable, .addrStrobe, .memDisable
  );

  mcu_bus_model MCU (
    .mclk, .mcuAddr, .mcuWrData, .mcuWr, .mcuRd, .ioSelect, .mcuRdData, .mcuRdValid
  );

  // ------------------------------------------------------------
  // Clock, watchdog, helpers
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Whole run needs well under a thousand cycles; a hang ends here
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chkrd(input logic [7:0] a, input byte_type e);
    MCU.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask

  task automatic tdone(input string s);
    $display("end of test %s", s);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {padIn, oeTerm, cellPinSel, cellLogic, ecsTerm, ecsActiveHigh} = '0;
    {addrOutA, addrOutB, busDriveData, logicClkEn, imcLatchEn, routeFirstToB} = '0;
    {routeSecondToC, dataPortMode, periphMode, busDriveEn, dbeEnable} = '0;
    {aleOnPin, clkinOnPin, csiOnPin, powerDown} = '0;
    step(8);
    sys_rst = 1'b0;
    // Write, one idle cycle, then read back
    foreach (rows[i]) begin
      MCU.wr(rows[i][23:16], rows[i][15:8]);
      chkrd(rows[i][23:16], rows[i][7:0]);
    end
    tdone("table");
    // Second reset in mid-run brings everything back to inputs and defaults
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    foreach (zeroAddrs[i]) chkrd(zeroAddrs[i], 8'h00);
    `CHK(padOe, '0)
    tdone("reset");
    oeTerm[1] = 8'h30;
    MCU.wr(8'h19, 8'h0f);
    MCU.wr(8'h05, 8'haa);
    chkrd(8'h15, 8'h3f);
    `CHK(padOe[1], 8'h3f)
    `CHK(padOut[1] & padOe[1], 8'h2a)
    chkrd(8'h05, 8'haa);
    padIn[2] = 8'h96;
    padIn[0] = 8'h3c;
    step(5);
    chkrd(8'h02, 8'h96);
    `CHK(busPinData, 8'h3c)
    tdone("direction");
    MCU.wr(8'h1e, 8'hff);
    MCU.wr(8'h1a, 8'hff);
    MCU.wr(8'h06, 8'h0f);
    chkrd(8'h06, 8'h0f);
    MCU.wr(8'h1c, 8'hff);
    MCU.wr(8'h1d, 8'hff);
    MCU.wr(8'h1f, 8'hff);
    step(2);
    `CHK(padOe[2], 8'hf0)
    `CHK(padOut[2], 8'h00)
    `CHK(slewFast[0], 8'h0f)
    `CHK(slewFast[1], 8'h0f)
    `CHK(slewFast[3], 8'h07)
    tdone("drive");
    MCU.wr(8'h0c, 8'hf0);
    MCU.wr(8'h08, 8'hff);
    chkrd(8'h08, 8'h0f);
    cellLogic = 16'h00a0;
    logicClkEn = 1'b1;
    step(1);
    logicClkEn = 1'b0;
    step(2);
    `CHK(cellOutputs[7:0], 8'ha0)
    {routeFirstToB, cellPinSel[1]} = {1'b1, 8'hff};
    MCU.wr(8'h19, 8'hff);
    // Port B back to push-pull so routed highs reach the pins
    MCU.wr(8'h1d, 8'h00);
    MCU.wr(8'h09, 8'h5c);
    {routeSecondToC, cellPinSel[2]} = {1'b1, 8'hff};
    step(2);
    `CHK(padOut[1], 8'ha0)
    `CHK(padOe[2], 8'ha3)
    tdone("cells");
    padIn[1] = 8'h5a;
    step(5);
    imcLatchEn = 1'b1;
    step(1);
    imcLatchEn = 1'b0;
    chkrd(8'h11, 8'h5a);
    `CHK(inputCellBus[1], 8'h5a)
    {dbeEnable, aleOnPin, clkinOnPin, padIn[3], ecsTerm, ecsActiveHigh} =
      {3'b111, 8'h03, 6'b101001};
    cellPinSel[3] = 8'h07;
    MCU.wr(8'h1b, 8'h07);
    step(5);
    `CHK({dataByteEnable, addrStrobe}, 2'b11)
    `CHK(cellOutputs, 16'h00a0)
    `CHK(padOut[3][2:0], 3'b011)
    `CHK(padOe[3], 8'h07)
    {csiOnPin, padIn[3]} = {1'b1, 8'h05};
    step(5);
    `CHK(memDisable, 1'b1)
    MCU.rd(8'h1b, d, ok);
    `CHK(ok, 1'b0)
    csiOnPin = 1'b0;
    tdone("dedicated");
    addrOutA = 8'h7e;
    MCU.wr(8'h1c, 8'h00);
    MCU.wr(8'h20, 8'hff);
    MCU.wr(8'h18, 8'hff);
    step(2);
    `CHK(padOut[0], 8'h7e)
    {dataPortMode, busDriveEn, busDriveData} = {2'b11, 8'hc3};
    step(2);
    `CHK({padOe[0], padOut[0]}, 16'hffc3)
    powerDown = 1'b1;
    MCU.wr(8'h05, 8'h55);
    MCU.rd(8'h19, d, ok);
    `CHK(ok, 1'b0)
    `CHK({padOe[0], padOe[1]}, 16'h00ff)
    {dataPortMode, periphMode} = 2'b01;
    step(2);
    `CHK(padOe[0], 8'h00)
    powerDown = 1'b0;
    step(2);
    `CHK(padOe[0], 8'hff)
    chkrd(8'h05, 8'haa);
    tdone("power");
    report_and_stop();
  end
endmodule
`default_nettype wire
